// *** pkg/owct_cfg.svh ***
`ifndef OWCT_CFG_SVH
`define OWCT_CFG_SVH

// Option word 0 field positions
`define OWCT_WORD_W 13
`define OWCT_RSV_MSB 12
`define OWCT_RSV_LSB 9
`define OWCT_RSV_ONES 4'hF
`define OWCT_BIT_PERIOD 8
`define OWCT_BIT_WDT_N 7
`define OWCT_BIT_VARIANT 6
`define OWCT_BIT_XFREQ 5
`define OWCT_BIT_OSCTYPE 4
`define OWCT_BIT_POWER 3
`define OWCT_PROT_MSB 2
`define OWCT_PROT_LSB 0
`define OWCT_PROT_OFF 3'h7

// Oscillator periods per instruction cycle, as last phase index
`define OWCT_LAST_SHORT 2'h1
`define OWCT_LAST_LONG 2'h3
// Cycles the fuse synchroniser needs before capture
`define OWCT_LOAD_WAIT 2'h2

// Instruction encodings
`define OWCT_OP_RET 13'h0012
`define OWCT_OP_RETURN_INTERRUPT_OP 13'h0013
`define OWCT_OP_TBL 13'h0020
`define OWCT_PC_REG 6'h02
`define OWCT_CALL_PFX 3'h4
`define OWCT_JMP_PFX 3'h5
`define OWCT_RETURN_LITERAL_OP_PFX 5'h18
`define OWCT_BITOP_PFX 2'h1
`define OWCT_DJZ_PFX 6'h0B
`define OWCT_JZ_PFX 6'h0F

// Register port map
`define OWCT_REG_CTRL 4'h0
`define OWCT_REG_STATUS 4'h4
`define OWCT_REG_CYCCNT 4'h8
`define OWCT_CTRL_RUN 0
`define OWCT_CTRL_RST 1'h1

`endif

// *** pkg/owct_pkg.sv ***
package owct_pkg;

    // Oscillator mode decoded from option word 0
    typedef enum logic [1:0] {
        OWCT_OSC_RC,
        OWCT_OSC_HXT,
        OWCT_OSC_LXT,
        OWCT_OSC_UNDEF
    } owct_osc_mode_t;

    // Instruction cycle sequencer
    typedef enum logic [1:0] {
        OWCT_ST_LOAD,
        OWCT_ST_CYC1,
        OWCT_ST_CYC2
    } owct_state_t;

endpackage

// *** logic/owct_top.sv ***
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "owct_cfg.svh"

module owct_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [12:0] otp_word0,
    input wire logic [12:0] otp_word1,
    input wire logic instr_valid,
    input wire logic [12:0] instr_word,
    input wire logic skip_true,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic wdt_en,
    output logic variant_a,
    output logic xtal_high_range,
    output owct_pkg::owct_osc_mode_t osc_mode_select,
    output logic osc_high_power,
    output logic code_protect_en,
    output logic cfg_loaded,
    output logic cyc_start,
    output logic instr_done,
    output logic second_cycle,
    output logic tmr_tick,
    output logic [12:0] prog_word0,
    output logic [12:0] prog_word1
);

    // Fuse synchroniser and captured words
    logic [12:0] w0_s1_ff;
    logic [12:0] w0_s2_ff;
    logic [12:0] w1_s1_ff;
    logic [12:0] w1_s2_ff;
    logic [12:0] opt0_ff;
    logic [12:0] opt1_ff;
    logic [1:0] ld_cnt_ff;
    logic loaded_ff;
    logic load_now;

    // Decoded option outputs
    logic long_ff;
    logic wdt_en_ff;
    logic variant_a_ff;
    logic xtal_hi_ff;
    owct_pkg::owct_osc_mode_t osc_mode_ff;
    logic power_ff;
    logic protect_ff;

    // Sequencer
    owct_pkg::owct_state_t state_ff;
    owct_pkg::owct_state_t nxt_state;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic two_ff;
    logic nxt_two;
    logic [1:0] last_ph;
    logic cyc_start_ff;
    logic done_ff;
    logic second_ff;
    logic tick_ff;

    // Register port
    logic run_ff;
    logic nxt_run;
    logic [15:0] cyc_cnt_ff;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic cyc_end;

    // Flags instructions that occupy two instruction cycles
    function automatic logic owct_needs_two(input logic [12:0] iw, input logic sk);
        logic is_branch;
        logic is_skip;
        logic pc_wr;
        begin
            is_branch = (iw[12:10] == `OWCT_CALL_PFX) || (iw[12:10] == `OWCT_JMP_PFX)
                || (iw[12:8] == `OWCT_RETURN_LITERAL_OP_PFX) || (iw == `OWCT_OP_RET)
                || (iw == `OWCT_OP_RETURN_INTERRUPT_OP);
            // Bit tests and inc/dec-then-test forms only cost extra when taken
            is_skip = ((iw[12:11] == `OWCT_BITOP_PFX) && iw[10])
                || (iw[12:7] == `OWCT_DJZ_PFX) || (iw[12:7] == `OWCT_JZ_PFX);
            // Any register-destination op aimed at the PC; register class
            // does not matter, I/O and general alike
            pc_wr = ((iw[12:11] == 2'h0) && (iw[10:6] != 5'h00) && iw[6]
                && (iw[5:0] == `OWCT_PC_REG)) || (iw == `OWCT_OP_TBL);
            // Bit set/clear on the PC register also redirects flow
            pc_wr = pc_wr || ((iw[12:11] == `OWCT_BITOP_PFX) && !iw[10]
                && (iw[5:0] == `OWCT_PC_REG));
            owct_needs_two = is_branch || (is_skip && sk) || pc_wr;
        end
    endfunction

    // Two flops on fuse levels; they come from outside the clock
    always_ff @(posedge clk_sys) begin
        w0_s1_ff <= otp_word0;
        w0_s2_ff <= w0_s1_ff;
        w1_s1_ff <= otp_word1;
        w1_s2_ff <= w1_s1_ff;
    end

    // Wait for the synchroniser to fill before capture
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ld_cnt_ff <= 2'h0;
        end else if (ld_cnt_ff != `OWCT_LOAD_WAIT) begin
            ld_cnt_ff <= ld_cnt_ff + 2'h1;
        end
    end

    assign load_now = !loaded_ff && (ld_cnt_ff == `OWCT_LOAD_WAIT);

    // One capture per reset; fuse changes later are ignored
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            loaded_ff <= 1'b0;
            opt0_ff <= 13'h1FFF;
            opt1_ff <= 13'h0000;
        end else if (load_now) begin
            loaded_ff <= 1'b1;
            opt0_ff <= {`OWCT_RSV_ONES, w0_s2_ff[`OWCT_BIT_PERIOD:0]};
            opt1_ff <= w1_s2_ff;
        end
    end

    // Decode fields from the captured word; safe values until loaded
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            long_ff <= 1'b0;
            wdt_en_ff <= 1'b0;
            variant_a_ff <= 1'b0;
            xtal_hi_ff <= 1'b0;
            osc_mode_ff <= owct_pkg::OWCT_OSC_RC;
            power_ff <= 1'b0;
            protect_ff <= 1'b1;
        end else if (load_now) begin
            long_ff <= w0_s2_ff[`OWCT_BIT_PERIOD];
            wdt_en_ff <= !w0_s2_ff[`OWCT_BIT_WDT_N];
            variant_a_ff <= w0_s2_ff[`OWCT_BIT_VARIANT];
            // Range bit is masked when the RC source is chosen
            xtal_hi_ff <= w0_s2_ff[`OWCT_BIT_OSCTYPE]
                && w0_s2_ff[`OWCT_BIT_XFREQ];
            power_ff <= w0_s2_ff[`OWCT_BIT_POWER];
            protect_ff <= w0_s2_ff[`OWCT_PROT_MSB:`OWCT_PROT_LSB]
                != `OWCT_PROT_OFF;
            if (!w0_s2_ff[`OWCT_BIT_OSCTYPE]) begin
                osc_mode_ff <= owct_pkg::OWCT_OSC_RC;
            end else if (w0_s2_ff[`OWCT_BIT_XFREQ]) begin
                osc_mode_ff <= owct_pkg::OWCT_OSC_HXT;
            end else if (!w0_s2_ff[`OWCT_BIT_POWER]) begin
                osc_mode_ff <= owct_pkg::OWCT_OSC_LXT;
            end else begin
                osc_mode_ff <= owct_pkg::OWCT_OSC_UNDEF;
            end
        end
    end

    assign last_ph = long_ff ? `OWCT_LAST_LONG : `OWCT_LAST_SHORT;
    assign cyc_end = run_ff && (state_ff != owct_pkg::OWCT_ST_LOAD)
        && (phase_ff == last_ph);

    // Sequencer next state; phase freezes while stopped
    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_two = two_ff;
        case (state_ff)
            owct_pkg::OWCT_ST_LOAD: begin
                nxt_phase = 2'h0;
                if (load_now) begin
                    nxt_state = owct_pkg::OWCT_ST_CYC1;
                end
            end
            owct_pkg::OWCT_ST_CYC1: begin
                if (run_ff) begin
                    if (phase_ff == 2'h0) begin
                        nxt_two = instr_valid && owct_needs_two(instr_word, skip_true);
                    end
                    if (phase_ff == last_ph) begin
                        nxt_phase = 2'h0;
                        // An idle slot without an instruction counts as one cycle
                        if (nxt_two) begin
                            nxt_state = owct_pkg::OWCT_ST_CYC2;
                        end
                    end else begin
                        nxt_phase = phase_ff + 2'h1;
                    end
                end
            end
            owct_pkg::OWCT_ST_CYC2: begin
                if (run_ff) begin
                    if (phase_ff == last_ph) begin
                        nxt_phase = 2'h0;
                        nxt_two = 1'b0;
                        nxt_state = owct_pkg::OWCT_ST_CYC1;
                    end else begin
                        nxt_phase = phase_ff + 2'h1;
                    end
                end
            end
            default: begin
                nxt_state = owct_pkg::OWCT_ST_LOAD;
                nxt_phase = 2'h0;
                nxt_two = 1'b0;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff <= owct_pkg::OWCT_ST_LOAD;
            phase_ff <= 2'h0;
            two_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            two_ff <= nxt_two;
        end
    end

    // Run bit after this edge; strobes then also mark a phase resumed after a stop
    assign nxt_run = (reg_wr && (reg_addr == `OWCT_REG_CTRL))
        ? reg_wdata[`OWCT_CTRL_RUN] : run_ff;

    // Registered strobes line up with the phase they describe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cyc_start_ff <= 1'b0;
            done_ff <= 1'b0;
            second_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            cyc_start_ff <= nxt_run && (nxt_state != owct_pkg::OWCT_ST_LOAD)
                && (nxt_phase == 2'h0);
            // One cycle unless flagged; default path
            done_ff <= nxt_run && (nxt_phase == last_ph)
                && (((nxt_state == owct_pkg::OWCT_ST_CYC1) && !nxt_two)
                || (nxt_state == owct_pkg::OWCT_ST_CYC2));
            second_ff <= nxt_state == owct_pkg::OWCT_ST_CYC2;
            // Timer tick once per instruction cycle: Fosc/2 or Fosc/4
            tick_ff <= nxt_run && (nxt_state != owct_pkg::OWCT_ST_LOAD)
                && (nxt_phase == last_ph);
        end
    end

    // Control bit and cycle counter; a clear on the edge that ends a cycle leaves a count of one
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            run_ff <= `OWCT_CTRL_RST;
            cyc_cnt_ff <= 16'h0000;
        end else begin
            run_ff <= nxt_run;
            if (cyc_end) begin
                cyc_cnt_ff <= (reg_wr && (reg_addr == `OWCT_REG_CYCCNT))
                    ? 16'h0001 : cyc_cnt_ff + 16'h0001;
            end else if (reg_wr && (reg_addr == `OWCT_REG_CYCCNT)) begin
                cyc_cnt_ff <= 16'h0000;
            end
        end
    end

    // Read mux; no option bit is on it, so code cannot see them
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `OWCT_REG_CTRL: nxt_rdata = {15'h0000, run_ff};
                `OWCT_REG_STATUS: nxt_rdata = {12'h000, phase_ff, second_ff, loaded_ff};
                `OWCT_REG_CYCCNT: nxt_rdata = cyc_cnt_ff;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign wdt_en = wdt_en_ff;
    assign variant_a = variant_a_ff;
    assign xtal_high_range = xtal_hi_ff;
    assign osc_mode_select = osc_mode_ff;
    assign osc_high_power = power_ff;
    assign code_protect_en = protect_ff;
    assign cfg_loaded = loaded_ff;
    assign cyc_start = cyc_start_ff;
    assign instr_done = done_ff;
    assign second_cycle = second_ff;
    assign tmr_tick = tick_ff;
    // Readback for the programmer pins only
    assign prog_word0 = opt0_ff;
    assign prog_word1 = opt1_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    chk_rsv_ones: assert property (
        loaded_ff |-> prog_word0[12:9] == 4'hF)
        else $error("reserved option bits not one");

    chk_short_period: assert property (disable iff (srst || !run_ff)
        cyc_start_ff && !long_ff |-> ##1 !cyc_start_ff ##1 cyc_start_ff)
        else $error("short cycle not two periods");

    chk_long_period: assert property (disable iff (srst || !run_ff)
        cyc_start_ff && long_ff |-> ##1 !cyc_start_ff [*3] ##1 cyc_start_ff)
        else $error("long cycle not four periods");

    chk_wdt_enable: assert property (
        $rose(loaded_ff) |-> wdt_en == !opt0_ff[7])
        else $error("watchdog enable wrong");

    chk_variant_sel: assert property (
        loaded_ff |-> variant_a == opt0_ff[6])
        else $error("variant select wrong");

    chk_xtal_gate: assert property (
        xtal_high_range |-> opt0_ff[4] && opt0_ff[5])
        else $error("crystal range active with RC source");

    chk_osc_source: assert property (
        loaded_ff |-> (osc_mode_select == owct_pkg::OWCT_OSC_RC) == !opt0_ff[4])
        else $error("oscillator source wrong");

    chk_drive_power: assert property (
        loaded_ff |-> osc_high_power == opt0_ff[3])
        else $error("drive power wrong");

    chk_protect_field: assert property (
        loaded_ff |-> code_protect_en == (opt0_ff[2:0] != 3'h7))
        else $error("protect decode wrong");

    chk_low_crystal: assert property (
        loaded_ff && opt0_ff[4] && !opt0_ff[5] && !opt0_ff[3]
        |-> osc_mode_select == owct_pkg::OWCT_OSC_LXT)
        else $error("low crystal mode missed");

    chk_one_cycle: assert property (disable iff (srst || !run_ff)
        state_ff == owct_pkg::OWCT_ST_CYC1 && phase_ff == 2'h0 && !long_ff
        && !(instr_valid && owct_needs_two(instr_word, skip_true))
        |-> ##1 instr_done)
        else $error("one-cycle instruction not done");

    chk_two_cycle: assert property (disable iff (srst || !run_ff)
        state_ff == owct_pkg::OWCT_ST_CYC1 && phase_ff == 2'h0 && !long_ff
        && instr_valid && owct_needs_two(instr_word, skip_true)
        |-> ##1 !instr_done ##2 instr_done && second_cycle)
        else $error("two-cycle instruction wrong length");

    chk_tick_rate: assert property (disable iff (srst || !run_ff)
        tmr_tick && long_ff |-> ##1 !tmr_tick [*3] ##1 tmr_tick)
        else $error("timer tick not Fosc/4");

    chk_cfg_held: assert property (
        loaded_ff && $past(loaded_ff)
        |-> $stable(wdt_en) && $stable(osc_mode_select) && $stable(long_ff))
        else $error("option decode changed while running");

    cov_long_mode: cover property (cyc_start_ff && long_ff);
    cov_two_cycle: cover property (second_ff && done_ff);
    cov_hxt_mode: cover property (osc_mode_ff == owct_pkg::OWCT_OSC_HXT);

endmodule

// *** test/owct_core_model.sv ***
`timescale 1ns/1ps

// Fuse programmer and core sequencer standing around the option block
module owct_core_model (
    input wire logic cyc_start,
    input wire logic cur_valid,
    input wire logic [12:0] cur_word,
    input wire logic cur_skip,
    input wire logic [12:0] cfg0_req,
    input wire logic [12:0] cfg1_req,
    output logic [12:0] otp_word0,
    output logic [12:0] otp_word1,
    output logic instr_valid,
    output logic [12:0] instr_word,
    output logic skip_true
);
    // Programmer clears the crystal range bit on an RC part
    assign otp_word0 = cfg0_req[4] ? cfg0_req : (cfg0_req & 13'h1FDF);
    assign otp_word1 = cfg1_req;
    // Off phase 0 the core bus shows inverted junk, so a late sample shows up
    assign instr_valid = cyc_start ? cur_valid : ~cur_valid;
    assign instr_word = cyc_start ? cur_word : ~cur_word;
    assign skip_true = cyc_start ? cur_skip : ~cur_skip;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic clk_sys;
    logic srst;
    logic [12:0] cfg0_req;
    logic [12:0] cfg1_req;
    logic cur_valid;
    logic cur_skip;
    logic [12:0] cur_word;
    logic [12:0] otp_word0;
    logic [12:0] otp_word1;
    logic instr_valid;
    logic skip_true;
    logic [12:0] instr_word;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic wdt_en;
    logic variant_a;
    logic xtal_high_range;
    owct_pkg::owct_osc_mode_t osc_mode_select;
    logic osc_high_power;
    logic code_protect_en;
    logic cfg_loaded;
    logic cyc_start;
    logic instr_done;
    logic second_cycle;
    logic tmr_tick;
    logic [12:0] prog_word0;
    logic [12:0] prog_word1;
    int error_cnt;
    int tests_run;
    integer seed;
    logic [12:0] cfg_now;
    logic [15:0] rd_val;
    // Instruction mix: plain, jumps, returns, PC writes, bit ops, skips
    logic [12:0] op_tab [0:16] = '{13'h0000, 13'h1400, 13'h1000, 13'h1800, 13'h0012,
        13'h0013, 13'h0020, 13'h0042, 13'h00C2, 13'h0043, 13'h0B82, 13'h0B85,
        13'h0C05, 13'h0C05, 13'h0585, 13'h0785, 13'h0785};
    logic [16:0] skip_tab = 17'h0D000;
    logic [16:0] two_tab = 17'h0D5FE;

    owct_top u_owct_top (.clk_sys(clk_sys), .srst(srst), .otp_word0(otp_word0),
        .otp_word1(otp_word1), .instr_valid(instr_valid), .instr_word(instr_word),
        .skip_true(skip_true), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_en(wdt_en),
        .variant_a(variant_a), .xtal_high_range(xtal_high_range),
        .osc_mode_select(osc_mode_select), .osc_high_power(osc_high_power),
        .code_protect_en(code_protect_en), .cfg_loaded(cfg_loaded),
        .cyc_start(cyc_start), .instr_done(instr_done), .second_cycle(second_cycle),
        .tmr_tick(tmr_tick), .prog_word0(prog_word0), .prog_word1(prog_word1));

    owct_core_model u_owct_core_model (.cyc_start(cyc_start), .cur_valid(cur_valid),
        .cur_word(cur_word), .cur_skip(cur_skip), .cfg0_req(cfg0_req),
        .cfg1_req(cfg1_req), .otp_word0(otp_word0), .otp_word1(otp_word1),
        .instr_valid(instr_valid), .instr_word(instr_word), .skip_true(skip_true));

    // 20 MHz oscillator
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Mode decode worked out from the bit table
    function automatic logic [1:0] exp_mode(input logic [12:0] w);
        if (!w[4]) return owct_pkg::OWCT_OSC_RC;
        if (w[5]) return owct_pkg::OWCT_OSC_HXT;
        if (!w[3]) return owct_pkg::OWCT_OSC_LXT;
        return owct_pkg::OWCT_OSC_UNDEF;
    endfunction

    task automatic check_cfg(input logic [12:0] w, input logic [12:0] id);
        chk({15'h0, wdt_en}, {15'h0, ~w[7]});
        chk({15'h0, variant_a}, {15'h0, w[6]});
        chk({15'h0, xtal_high_range}, {15'h0, w[5] & w[4]});
        chk({14'h0, osc_mode_select}, {14'h0, exp_mode(w)});
        chk({15'h0, osc_high_power}, {15'h0, w[3]});
        chk({15'h0, code_protect_en}, {15'h0, w[2:0] != 3'h7});
        chk({3'h0, prog_word0}, {3'h0, 4'hF, w[8:0]});
        chk({3'h0, prog_word1}, {3'h0, id});
    endtask

    // Bus cycles: one-cycle strobes, read data in the following cycle only
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Wait for a cycle's last phase so the next edge opens a fresh cycle
    task automatic sync_tick();
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (tmr_tick !== 1'b1 && k < 20);
        chk({15'h0, tmr_tick}, 16'h0001);
    endtask

    task automatic run_instr(input int i);
        int n;
        int ticks;
        int sc;
        int per;
        per = cfg_now[8] ? 4 : 2;
        @(posedge clk_sys);
        cur_word <= op_tab[i];
        cur_skip <= skip_tab[i];
        cur_valid <= 1'b1;
        #1;
        chk({15'h0, cyc_start}, 16'h0001);
        n = 0;
        ticks = 0;
        sc = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
            ticks += (tmr_tick === 1'b1);
            sc += (second_cycle === 1'b1);
        end while (instr_done !== 1'b1 && n < 20);
        chk(16'(n), 16'(two_tab[i] ? 2 * per - 1 : per - 1));
        chk(16'(ticks), 16'(two_tab[i] ? 2 : 1));
        chk(16'(sc), 16'(two_tab[i] ? per : 0));
    endtask

    // Hang guard, well beyond the expected thousand or so cycles
    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end

    initial begin
        int n;
        seed = 32'h20f0d546;
        error_cnt = 0;
        tests_run = 0;
        srst = 1'b1;
        cfg0_req = 13'h1FFF;
        cfg1_req = 13'h0000;
        cur_valid = 1'b0;
        cur_skip = 1'b0;
        cur_word = 13'h0000;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        for (int c = 0; c < 7; c++) begin
            @(posedge clk_sys);
            srst <= 1'b1;
            cur_valid <= 1'b0;
            cfg0_req <= (c == 0) ? 13'h1FFF : (c == 1) ? 13'h0000 : (c == 2) ? 13'h0017 :
                (c == 3) ? 13'h0118 : 13'($random(seed));
            cfg1_req <= 13'($random(seed));
            repeat (10) @(posedge clk_sys);
            #1;
            chk({14'h0, cfg_loaded, code_protect_en}, 16'h0001);
            cfg_now = otp_word0;
            @(posedge clk_sys);
            srst <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_sys);
                #1;
                n++;
            end while (cfg_loaded !== 1'b1 && n < 10);
            chk(16'(n), 16'h0003);
            check_cfg(cfg_now, otp_word1);
            // Refusing to follow a fuse change proves the capture is one-shot
            @(posedge clk_sys);
            cfg0_req <= ~cfg_now;
            cfg1_req <= ~otp_word1;
            repeat (6) @(posedge clk_sys);
            #1;
            check_cfg(cfg_now, ~otp_word1);
            if (c == 0) begin
                reg_read(4'h4, rd_val);
                chk(rd_val & 16'h0001, 16'h0001);
                // Read data must fall back to zero one cycle later
                @(posedge clk_sys);
                #1;
                chk(reg_rdata, 16'h0000);
                reg_write(4'h0, 16'h0000);
                reg_write(4'h8, 16'h0000);
                n = 0;
                repeat (8) begin
                    @(posedge clk_sys);
                    #1;
                    n += (cyc_start === 1'b1);
                end
                chk(16'(n), 16'h0000);
                reg_read(4'h8, rd_val);
                chk(rd_val, 16'h0000);
                reg_read(4'h0, rd_val);
                chk(rd_val, 16'h0000);
                // Nothing else is mapped, so option bits never leak out
                for (int a = 1; a < 16; a++) begin
                    if (a != 4 && a != 8) begin
                        reg_read(4'(a), rd_val);
                        chk(rd_val, 16'h0000);
                    end
                end
                reg_write(4'h0, 16'h0001);
                reg_read(4'h0, rd_val);
                chk(rd_val & 16'h0001, 16'h0001);
                // Clear in phase 0 of a long cycle; two cycles end before the read
                sync_tick();
                reg_write(4'h8, 16'h0000);
                repeat (8) @(posedge clk_sys);
                reg_read(4'h8, rd_val);
                chk(rd_val, 16'h0002);
            end
            sync_tick();
            for (int i = 0; i < 17; i++) begin
                run_instr(i);
            end
        end
        print_verdict();
    end
endmodule
